// [src/mdt_pkg.sv]
`default_nettype none
package mdt_pkg;
    // ----------------------------------------
    // time base
    // ----------------------------------------
    localparam int unsigned CLK_HZ       = 40_000_000;
    localparam int unsigned TIME_BASE_MS = 1000;
    localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * TIME_BASE_MS;
    localparam int unsigned DIV_W        = 26;
    localparam int unsigned TW           = 24;
    localparam int unsigned STD_DELAY_S  = 10;
    localparam int unsigned CHECK_WIN_S  = 30;
    localparam logic [TW-1:0] STD_TICKS  = TW'(STD_DELAY_S * 1000 / TIME_BASE_MS);
    localparam logic [TW-1:0] CHECK_TICKS = TW'(CHECK_WIN_S * 1000 / TIME_BASE_MS);
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam int unsigned AW = 8;
    localparam int unsigned DW = 32;
    localparam logic [AW-1:0] OFS_CTRL    = 8'h00;
    localparam logic [AW-1:0] OFS_ADD     = 8'h04;
    localparam logic [AW-1:0] OFS_CYCLE   = 8'h08;
    localparam logic [AW-1:0] OFS_EVAL    = 8'h0C;
    localparam logic [AW-1:0] OFS_MONITOR = 8'h10;
    localparam logic [AW-1:0] OFS_IMPCNT  = 8'h14;
    localparam logic [AW-1:0] OFS_FACTOR  = 8'h18;
    localparam logic [AW-1:0] OFS_STATUS  = 8'h1C;
    localparam int unsigned CTRL_W = 11;
    localparam int unsigned B_ALERT    = 0;
    localparam int unsigned B_SEMI     = 1;
    localparam int unsigned B_PRESENCE = 2;
    localparam int unsigned B_TW_INDEP = 3;
    localparam int unsigned B_CYCLIC   = 4;
    localparam int unsigned B_RETRIG   = 5;
    localparam int unsigned B_EVAL     = 6;
    localparam int unsigned B_BEG0     = 7;
    localparam int unsigned B_END0     = 9;
    localparam logic [CTRL_W-1:0] CTRL_RST   = 11'h000;
    localparam logic [15:0]       TIME_RST   = 16'h0000;
    localparam logic [7:0]        IMPCNT_RST = 8'h04;
    localparam logic [7:0]        FACTOR_RST = 8'h01;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_EVAL   = 6'h02,
        ST_CHECK  = 6'h04,
        ST_MOTION = 6'h08,
        ST_STD    = 6'h10,
        ST_ADD    = 6'h20
    } mdt_state_e;
    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [15:0]       add_delay;
        logic [15:0]       cycle;
        logic [15:0]       eval;
        logic [15:0]       monitor;
        logic [7:0]        imp_count;
        logic [7:0]        factor;
    } mdt_cfg_s;
    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic          wr;
        logic          rd;
    } mdt_bus_s;
endpackage
`default_nettype wire

// [src/mdt_timer.sv]
`timescale 1ns/100ps
`default_nettype none
module mdt_timer #(
    parameter int unsigned W = 24
) (
    input  wire logic         ref_clk,
    input  wire logic         reset,
    input  wire logic         tick,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output logic              expired
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } mdt_tmr_s;

    mdt_tmr_s r;
    mdt_tmr_s next_r;

    // ----------------------------------------
    // down counter on the shared time base
    // ----------------------------------------
    always_comb begin
        next_r = r;
        if (load) begin
            next_r.cnt = load_val;
        end else if (tick && r.cnt != '0) begin
            next_r.cnt = r.cnt - W'(1);
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign expired = (r.cnt == '0);
endmodule // mdt_timer
`default_nettype wire

// [src/mdt_core.sv]
// Functional notes
// - total delay is ten seconds then additional
// - new motion retriggers unless B_PRESENCE is set and switch-off brightness exceeded
// - detection end restores brightness-dependent operation unless B_TW_INDEP is set
// - per-output enable for begin telegram
// - cyclic telegrams during motion and standard, in additional only on retrigger
// - retrigger in additional: restart, resume or send
// - cyclic telegrams spaced by configured interval
// - retrigger telegram only during additional delay
// - evaluation delay then thirty second check window
// - empty check window sends nothing, rearms evaluation
// - evaluation delay covers both outputs and extensions
// - no evaluation delay in semi-automatic or alert
// - alert counts impulses within monitoring period
// - alert impulses retrigger, end message after expiry
// - alert begin and end messages configurable
// - external motion handled like local motion
// - external silence starts additional delay, then end
// - alert monitoring cleared at begin, restarts after
// - new factor used only at next restart
`timescale 1ns/100ps
`default_nettype none
module mdt_core
    import mdt_pkg::*;
#(
    parameter int unsigned TICK_CYC = mdt_pkg::TICK_CYCLES
) (
    input  wire logic                  ref_clk,
    input  wire logic                  reset,
    input  wire mdt_pkg::mdt_bus_s     bus,
    output logic [mdt_pkg::DW-1:0]     rdata,
    input  wire logic                  heat_motion_sensor,
    input  wire logic                  ext_motion,
    input  wire logic                  bright_over,
    output logic [1:0]                 begin_tel,
    output logic [1:0]                 end_tel,
    output logic                       detect_active,
    output logic                       brightness_dep
);
    import mdt_pkg::*;

    typedef struct packed {
        mdt_cfg_s      cfg;
        logic [DW-1:0] rdata;
        mdt_state_e    st;
        logic          sync1;
        logic          sync2;
        logic          motion_d;
        logic [DIV_W-1:0] div;
        logic          tick;
        logic [7:0]    imp_cnt;
        logic          mon_run;
        logic          beg_ev;
        logic          end_ev;
        logic          detect;
        logic          bdep;
    } mdt_core_s;

    mdt_core_s r;
    mdt_core_s next_r;

    logic          dly_load;
    logic [TW-1:0] dly_val;
    logic          dly_exp;
    logic          cyc_load;
    logic          cyc_exp;
    logic          mon_load;
    logic          mon_exp;
    logic [TW-1:0] add_val;
    logic [7:0]    cnt_new;
    logic          sensing;
    logic          local_imp;
    logic          any_imp;
    logic          eval_on;
    logic          retrig_ok;
    logic          cyc_on;
    logic          retrig_tel;

    // ----------------------------------------
    // timers
    // ----------------------------------------
    mdt_timer #(.W(TW)) u_dly (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .tick     (r.tick),
        .load     (dly_load),
        .load_val (dly_val),
        .expired  (dly_exp)
    );

    mdt_timer #(.W(TW)) u_cyc (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .tick     (r.tick),
        .load     (cyc_load),
        .load_val ({8'h00, r.cfg.cycle}),
        .expired  (cyc_exp)
    );

    mdt_timer #(.W(TW)) u_mon (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .tick     (r.tick),
        .load     (mon_load),
        .load_val ({8'h00, r.cfg.monitor}),
        .expired  (mon_exp)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_r = r;
        dly_load = 1'b0;
        dly_val = '0;
        cyc_load = 1'b0;
        mon_load = 1'b0;
        cnt_new = '0;
        next_r.beg_ev = 1'b0;
        next_r.end_ev = 1'b0;
        next_r.rdata = '0;

        // first stage is read only by the second stage
        next_r.sync1 = heat_motion_sensor;
        next_r.sync2 = r.sync1;
        next_r.motion_d = r.sync2;
        sensing = r.sync2;
        local_imp = r.sync2 & ~r.motion_d;
        any_imp = local_imp | ext_motion;

        // one common seconds tick for every timer
        next_r.tick = 1'b0;
        if (r.div == DIV_W'(TICK_CYC - 1)) begin
            next_r.div = '0;
            next_r.tick = 1'b1;
        end else begin
            next_r.div = r.div + DIV_W'(1);
        end

        // factor sampled only here, so a running delay keeps its length
        add_val = TW'({8'h00, r.cfg.add_delay} * {16'h0000, r.cfg.factor});
        eval_on = r.cfg.ctrl[B_EVAL] & ~r.cfg.ctrl[B_ALERT]
                  & ~r.cfg.ctrl[B_SEMI];
        retrig_ok = ~(r.cfg.ctrl[B_PRESENCE] & bright_over);
        cyc_on = r.cfg.ctrl[B_CYCLIC];
        retrig_tel = ~cyc_on & r.cfg.ctrl[B_RETRIG];

        unique case (r.st)
            ST_IDLE: begin
                if (r.cfg.ctrl[B_ALERT]) begin
                    if (any_imp) begin
                        // after expiry the impulse opens a new period
                        if (!r.mon_run || mon_exp) begin
                            cnt_new = 8'h01;
                            mon_load = 1'b1;
                        end else begin
                            cnt_new = r.imp_cnt + 8'h01;
                        end
                        next_r.imp_cnt = cnt_new;
                        next_r.mon_run = 1'b1;
                        if (cnt_new >= r.cfg.imp_count) begin
                            next_r.beg_ev = 1'b1;
                            next_r.detect = 1'b1;
                            next_r.bdep = 1'b1;
                            next_r.imp_cnt = '0;
                            next_r.mon_run = 1'b0;
                            cyc_load = 1'b1;
                            next_r.st = ST_STD;
                            dly_load = 1'b1;
                            dly_val = STD_TICKS;
                        end
                    end else if (r.mon_run && mon_exp) begin
                        next_r.imp_cnt = '0;
                        next_r.mon_run = 1'b0;
                    end
                end else if (any_imp) begin
                    if (eval_on) begin
                        next_r.st = ST_EVAL;
                        dly_load = 1'b1;
                        dly_val = {8'h00, r.cfg.eval};
                    end else begin
                        next_r.beg_ev = 1'b1;
                        next_r.detect = 1'b1;
                        next_r.bdep = 1'b1;
                        cyc_load = 1'b1;
                        if (local_imp) begin
                            next_r.st = ST_MOTION;
                        end else begin
                            next_r.st = ST_ADD;
                            dly_load = 1'b1;
                            dly_val = add_val;
                        end
                    end
                end
            end
            ST_EVAL: begin
                if (dly_exp) begin
                    next_r.st = ST_CHECK;
                    dly_load = 1'b1;
                    dly_val = CHECK_TICKS;
                end
            end
            ST_CHECK: begin
                if (sensing || ext_motion) begin
                    next_r.beg_ev = 1'b1;
                    next_r.detect = 1'b1;
                    next_r.bdep = 1'b1;
                    cyc_load = 1'b1;
                    if (sensing) begin
                        next_r.st = ST_MOTION;
                    end else begin
                        next_r.st = ST_ADD;
                        dly_load = 1'b1;
                        dly_val = add_val;
                    end
                end else if (dly_exp) begin
                    next_r.st = ST_IDLE;
                end
            end
            ST_MOTION: begin
                if (cyc_on && cyc_exp) begin
                    next_r.beg_ev = 1'b1;
                    cyc_load = 1'b1;
                end
                // standard delay runs from the last active motion signal
                if (!sensing) begin
                    next_r.st = ST_STD;
                    dly_load = 1'b1;
                    dly_val = STD_TICKS;
                end
            end
            ST_STD: begin
                if (cyc_on && cyc_exp) begin
                    next_r.beg_ev = 1'b1;
                    cyc_load = 1'b1;
                end
                // no retrigger telegram during the standard delay
                if (any_imp && retrig_ok) begin
                    next_r.st = local_imp ? ST_MOTION : ST_STD;
                    dly_load = ~local_imp;
                    dly_val = STD_TICKS;
                end else if (dly_exp) begin
                    next_r.st = ST_ADD;
                    dly_load = 1'b1;
                    dly_val = add_val;
                end
            end
            ST_ADD: begin
                if (any_imp && retrig_ok) begin
                    if (cyc_on && cyc_exp) begin
                        next_r.beg_ev = 1'b1;
                        cyc_load = 1'b1;
                    end else if (retrig_tel) begin
                        next_r.beg_ev = 1'b1;
                    end
                    if (local_imp) begin
                        next_r.st = ST_MOTION;
                    end else begin
                        // extensions repeat telegrams while they see motion
                        dly_load = 1'b1;
                        dly_val = add_val;
                    end
                end else if (dly_exp) begin
                    next_r.st = ST_IDLE;
                    next_r.end_ev = 1'b1;
                    next_r.detect = 1'b0;
                    next_r.bdep = ~r.cfg.ctrl[B_TW_INDEP];
                end
            end
        endcase

        // ----------------------------------------
        // register port
        // ----------------------------------------
        if (bus.wr) begin
            unique case (bus.addr)
                OFS_CTRL:    next_r.cfg.ctrl = bus.wdata[CTRL_W-1:0];
                OFS_ADD:     next_r.cfg.add_delay = bus.wdata[15:0];
                OFS_CYCLE:   next_r.cfg.cycle = bus.wdata[15:0];
                OFS_EVAL:    next_r.cfg.eval = bus.wdata[15:0];
                OFS_MONITOR: next_r.cfg.monitor = bus.wdata[15:0];
                OFS_IMPCNT:  next_r.cfg.imp_count = bus.wdata[7:0];
                OFS_FACTOR:  next_r.cfg.factor = bus.wdata[7:0];
                default: begin
                end
            endcase
        end
        if (bus.rd) begin
            unique case (bus.addr)
                OFS_CTRL:    next_r.rdata = {21'h000000, r.cfg.ctrl};
                OFS_ADD:     next_r.rdata = {16'h0000, r.cfg.add_delay};
                OFS_CYCLE:   next_r.rdata = {16'h0000, r.cfg.cycle};
                OFS_EVAL:    next_r.rdata = {16'h0000, r.cfg.eval};
                OFS_MONITOR: next_r.rdata = {16'h0000, r.cfg.monitor};
                OFS_IMPCNT:  next_r.rdata = {24'h000000, r.cfg.imp_count};
                OFS_FACTOR:  next_r.rdata = {24'h000000, r.cfg.factor};
                OFS_STATUS:  next_r.rdata = {14'h0000, r.bdep, r.detect,
                                             r.imp_cnt, 2'h0, r.st};
                default:     next_r.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            r <= '0;
            r.st <= ST_IDLE;
            r.bdep <= 1'b1;
            r.cfg.ctrl <= CTRL_RST;
            r.cfg.add_delay <= TIME_RST;
            r.cfg.cycle <= TIME_RST;
            r.cfg.eval <= TIME_RST;
            r.cfg.monitor <= TIME_RST;
            r.cfg.imp_count <= IMPCNT_RST;
            r.cfg.factor <= FACTOR_RST;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_out
            assign begin_tel[gi] = r.beg_ev & r.cfg.ctrl[B_BEG0 + gi];
            assign end_tel[gi] = r.end_ev & r.cfg.ctrl[B_END0 + gi];
        end
    endgenerate

    assign rdata = r.rdata;
    assign detect_active = r.detect;
    assign brightness_dep = r.bdep;
endmodule // mdt_core
`default_nettype wire

// [tb/mdt_ext_model.sv]
`timescale 1ns/100ps
`default_nettype none
module mdt_ext_model #(
    parameter int unsigned PERIOD = 16
) (
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic present,
    output logic      ext_motion
);
    logic [15:0] cnt;
    // ----------------------------------------
    // repeat telegrams while motion stays
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cnt        <= 16'h0000;
            ext_motion <= 1'b0;
        end else if (present && cnt == 16'h0000) begin
            ext_motion <= 1'b1;
            cnt        <= 16'(PERIOD - 1);
        end else begin
            ext_motion <= 1'b0;
            cnt        <= present ? cnt - 16'h0001 : 16'h0000;
        end
    end
endmodule // mdt_ext_model
`default_nettype wire

// [tb/mdt_core_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module mdt_core_chk
    import mdt_pkg::*;
#(
    parameter int unsigned TICK_CYC = 8
) (
    input  wire logic                  ref_clk,
    input  wire logic                  reset,
    input  wire mdt_pkg::mdt_bus_s     bus,
    input  wire logic [mdt_pkg::DW-1:0] rdata,
    input  wire logic                  heat_motion_sensor,
    input  wire logic                  ext_motion,
    input  wire logic                  bright_over,
    input  wire logic [1:0]            begin_tel,
    input  wire logic [1:0]            end_tel,
    input  wire logic                  detect_active,
    input  wire logic                  brightness_dep
);
    import mdt_pkg::*;
    logic [CTRL_W-1:0] ctrl;
    logic [31:0]       quiet;
    // ----------------------------------------
    // shadow config, cycles since sensor high
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ctrl  <= CTRL_RST;
            quiet <= 32'hFFFF_FFFF;
        end else begin
            if (bus.wr && bus.addr == OFS_CTRL) begin
                ctrl <= bus.wdata[CTRL_W-1:0];
            end
            quiet <= heat_motion_sensor ? 32'h0 : quiet + 32'(quiet != 32'hFFFF_FFFF);
        end
    end
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (reset);
    a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 32'h0)
        else $error("read data not zero outside answer cycle");
    a_status_read: assert property ($past(bus.rd) && $past(bus.addr) == OFS_STATUS
        |-> rdata[31:16] == {14'h0, $past(brightness_dep), $past(detect_active)})
        else $error("status read disagrees with outputs");
    a_unmapped_zero: assert property ($past(bus.rd) && $past(bus.addr) > 8'h1C
        |-> rdata == 32'h0) else $error("unmapped read not zero");
    a_bright_detect: assert property ($past(detect_active) && detect_active
        |-> brightness_dep) else $error("detection without brightness dependence");
    a_bright_end: assert property ($fell(detect_active)
        |-> ##[0:2] brightness_dep == !ctrl[B_TW_INDEP]) else $error("end mode wrong");
    a_begin_cfg: assert property ((begin_tel & ~ctrl[B_BEG0+1:B_BEG0]) == 2'b00)
        else $error("begin telegram on disabled output");
    a_end_cfg: assert property ((end_tel & ~ctrl[B_END0+1:B_END0]) == 2'b00)
        else $error("end telegram on disabled output");
    a_end_drop: assert property (|end_tel |-> ##[0:1] !detect_active)
        else $error("end telegram while detection stays");
    a_ext_start: assert property (ext_motion && !detect_active
        && ctrl[B_EVAL] == 1'b0 && ctrl[B_ALERT] == 1'b0 && ctrl[B_SEMI] == 1'b0
        |-> ##[1:4] detect_active) else $error("external motion not started");
    a_std_hold: assert property ($fell(detect_active) && !ctrl[B_PRESENCE]
        |-> quiet >= 32'((STD_DELAY_S - 1) * TICK_CYC)) else $error("delay too short");
endmodule // mdt_core_chk
`default_nettype wire

// [tb/mdt_core_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module mdt_core_bench;
    import mdt_pkg::*;
    logic          ref_clk = 1'b0;
    logic          reset   = 1'b1;
    mdt_bus_s      bus     = '0;
    logic          sens    = 1'b0;
    logic          present = 1'b0;
    logic          bright  = 1'b0;
    logic          ext_motion;
    logic [DW-1:0] rdata;
    logic [1:0]    begin_tel;
    logic [1:0]    end_tel;
    logic          detect_active;
    logic          brightness_dep;
    logic [31:0]   d;
    int            n_errors = 0;
    int            n_tests  = 0;
    int            nb0, nb1, ne0, ne1;
    always #12.5 ref_clk = ~ref_clk;
    mdt_core #(.TICK_CYC(8)) mdt_core_i (.ref_clk(ref_clk), .reset(reset), .bus(bus),
        .rdata(rdata), .heat_motion_sensor(sens), .ext_motion(ext_motion),
        .bright_over(bright), .begin_tel(begin_tel), .end_tel(end_tel),
        .detect_active(detect_active), .brightness_dep(brightness_dep));
    mdt_ext_model #(.PERIOD(16)) mdt_ext_model_i (.ref_clk(ref_clk), .reset(reset),
        .present(present), .ext_motion(ext_motion));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        #1;
        v = rdata;
    endtask
    // counts telegram pulses over n cycles
    task automatic run(input int n);
        nb0 = 0;
        nb1 = 0;
        ne0 = 0;
        ne1 = 0;
        repeat (n) begin
            @(negedge ref_clk);
            nb0 += int'(begin_tel[0] === 1'b1);
            nb1 += int'(begin_tel[1] === 1'b1);
            ne0 += int'(end_tel[0] === 1'b1);
            ne1 += int'(end_tel[1] === 1'b1);
        end
        // end on a rising edge so later stimulus stays edge aligned
        @(posedge ref_clk);
    endtask
    task automatic pulse;
        @(posedge ref_clk);
        sens <= 1'b1;
        repeat (3) @(posedge ref_clk);
        sens <= 1'b0;
    endtask
    task automatic setup(input logic [10:0] c, input logic [15:0] add);
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        wr(OFS_CTRL, {21'h0, c});
        wr(OFS_ADD, {16'h0, add});
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs;
        setup(11'h7FF, 16'h0);
        rd(OFS_CTRL, d); chk(d, 32'h7FF);
        rd(OFS_IMPCNT, d); chk(d, 32'h4);
        rd(OFS_FACTOR, d); chk(d, 32'h1);
        wr(8'h40, 32'h0); rd(8'h40, d); chk(d, 32'h0);
        rd(OFS_STATUS, d); chk(d, 32'h0002_0001);
        $display("test regs done");
    endtask
    task automatic t_basic;
        setup(11'h780, 16'h1);
        wr(OFS_FACTOR, 32'h2);
        pulse;
        run(20); chk(nb0 + nb1, 2);
        run(70); chk(ne0, 0);
        wr(OFS_FACTOR, 32'h8);
        run(40); chk(ne0, 1);
        chk(ne1, 1);
        chk(detect_active, 0); chk(brightness_dep, 1);
        $display("test basic done");
    endtask
    task automatic t_ext;
        setup(11'h288, 16'h3);
        present <= 1'b1;
        run(10); chk(nb0, 1); chk(nb1, 0);
        run(40); chk(ne0, 0);
        present <= 1'b0;
        run(60); chk(ne0, 1);
        chk(brightness_dep, 0);
        rd(OFS_STATUS, d); chk(d[5:0], 32'h1);
        $display("test ext done");
    endtask
    task automatic t_retrig;
        setup(11'h0A0, 16'h6);
        pulse;
        run(10); chk(nb0, 1);
        pulse;
        run(110); chk(nb0, 0);
        pulse;
        run(10); chk(nb0, 1);
        run(200); chk(detect_active, 0);
        $display("test retrig done");
    endtask
    task automatic t_cyclic;
        setup(11'h090, 16'h5);
        wr(OFS_CYCLE, 32'h2);
        sens <= 1'b1;
        run(80); chk(nb0 >= 4 && nb0 <= 6, 1);
        sens <= 1'b0;
        run(72); chk(nb0 >= 3 && nb0 <= 6, 1);
        run(14);
        run(24); chk(nb0, 0);
        pulse;
        run(6); chk(nb0, 1);
        $display("test cyclic done");
    endtask
    task automatic t_eval;
        setup(11'h0C0, 16'h0);
        wr(OFS_EVAL, 32'h2);
        pulse;
        run(300); chk(nb0, 0); chk(detect_active, 0);
        sens <= 1'b1;
        run(10); chk(nb0, 0);
        run(40); chk(nb0, 1);
        sens <= 1'b0;
        $display("test eval done");
    endtask
    task automatic t_alert;
        setup(11'h2C1, 16'h0);
        wr(OFS_IMPCNT, 32'h3);
        wr(OFS_MONITOR, 32'hA);
        pulse;
        pulse;
        run(4); chk(nb0, 0);
        pulse;
        run(4); chk(nb0, 1);
        run(150); chk(ne0, 1);
        pulse;
        run(4); chk(nb0, 0);
        $display("test alert done");
    endtask
    task automatic t_bright;
        setup(11'h2C6, 16'h1);
        pulse;
        run(10); chk(nb0, 1);
        bright <= 1'b1;
        pulse;
        run(80); chk(ne0, 1);
        chk(ne1, 0);
        chk(nb0, 0);
        bright <= 1'b0;
        $display("test bright done");
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        t_regs;
        t_basic;
        t_ext;
        t_retrig;
        t_cyclic;
        t_eval;
        t_alert;
        t_bright;
        report_and_stop;
    end
    initial begin
        #500000;
        n_errors++;
        report_and_stop;
    end
endmodule // mdt_core_bench
bind mdt_core mdt_core_chk #(.TICK_CYC(TICK_CYC)) mdt_core_chk_i (.ref_clk(ref_clk),
    .reset(reset), .bus(bus), .rdata(rdata), .heat_motion_sensor(heat_motion_sensor),
    .ext_motion(ext_motion), .bright_over(bright_over), .begin_tel(begin_tel),
    .end_tel(end_tel), .detect_active(detect_active), .brightness_dep(brightness_dep));
`default_nettype wire
